// file: design/uart_rx_pkg.sv
package uart_rx_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_DATA    = 5'h00;
  localparam logic [4:0] OFS_STATUS  = 5'h04;
  localparam logic [4:0] OFS_CONTROL = 5'h08;
  localparam logic [4:0] OFS_FORMAT  = 5'h0C;
  localparam logic [4:0] OFS_BAUD    = 5'h10;

  // Status register fields
  localparam int ST_DONE   = 7;
  localparam int ST_FERR   = 4;
  localparam int ST_OVR    = 3;
  localparam int ST_PERR   = 2;
  localparam int ST_DSPEED = 1;

  // Control register fields
  localparam int CT_IRQ_EN = 7;
  localparam int CT_RX_ON  = 4;
  localparam int CT_NINTH  = 1;

  // Frame format register fields, size in bits 2:0
  localparam int FM_PAR_ON   = 5;
  localparam int FM_PAR_ODD  = 4;
  localparam int FM_TWO_STOP = 3;

  // Reset values, and the nine-bit size code
  localparam logic [2:0] SIZE_RST  = 3'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [7:0] BAUD_RST  = 8'h00;

  // Samples per bit and first voting sample
  localparam logic [4:0] SPB_NORMAL  = 5'h10;
  localparam logic [4:0] SPB_DOUBLE  = 5'h08;
  localparam logic [4:0] VOTE_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_DOUBLE = 5'h04;

  // Receive buffer entry layout
  localparam int ENTRY_W    = 12;
  localparam int EN_PERR    = 11;
  localparam int EN_OVR     = 10;
  localparam int EN_FERR    = 9;
  localparam int EN_B8      = 8;
  localparam int FIFO_DEPTH = 2;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP   = 5'b10000
  } rx_state_t;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [3:0] last_bit_idx(input logic [2:0] size);
    case (size)
      3'h0:    return 4'h4;
      3'h1:    return 4'h5;
      3'h2:    return 4'h6;
      3'h7:    return 4'h8;
      default: return 4'h7;
    endcase
  endfunction

endpackage

// file: design/baud_tick.sv
`timescale 1ns/1ps
`default_nettype none
module baud_tick
  import uart_rx_pkg::*;
(
  input  wire logic       clk_i,   // System clock
  input  wire logic       nrst_i,  // Async reset, active low
  input  wire logic       run_i,   // Divider runs
  input  wire logic [7:0] div_i,   // Divide by div_i + 1
  output logic            tick_o   // One-cycle sample enable
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } tick_state_t;

  tick_state_t s_r;
  tick_state_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!run_i) begin
      s_nxt.cnt = div_i;
    end else if (s_r.cnt == 8'h00) begin
      s_nxt.cnt  = div_i;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;

endmodule
`default_nettype wire

// file: design/rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module rx_fifo
  import uart_rx_pkg::*;
(
  input  wire logic               clk_i,    // System clock
  input  wire logic               nrst_i,   // Async reset, active low
  input  wire logic               push_i,   // Store din_i, ignored when full
  input  wire logic [ENTRY_W-1:0] din_i,    // Entry to store
  input  wire logic               pop_i,    // Drop head, ignored when empty
  input  wire logic               flush_i,  // Discard all entries
  output logic      [ENTRY_W-1:0] head_o,   // Oldest entry
  output logic      [1:0]         count_o,  // Entries held
  output logic                    full_o,   // Both slots used
  output logic                    empty_o   // Nothing held
);

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] mem;
    logic                               rd;
    logic [1:0]                         cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;

  always_comb begin
    logic do_push;
    logic do_pop;
    logic wr;
    s_nxt   = s_r;
    do_push = push_i && (s_r.cnt != 2'(FIFO_DEPTH));
    do_pop  = pop_i && (s_r.cnt != 2'h0);
    wr      = s_r.rd ^ s_r.cnt[0];
    if (flush_i) begin
      s_nxt.cnt = 2'h0;
      s_nxt.rd  = 1'b0;
    end else begin
      if (do_push) begin
        s_nxt.mem[wr] = din_i;
      end
      if (do_pop) begin
        s_nxt.rd = ~s_r.rd;
      end
      s_nxt.cnt = s_r.cnt + 2'(do_push) - 2'(do_pop);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign head_o  = s_r.mem[s_r.rd];
  assign count_o = s_r.cnt;
  assign full_o  = (s_r.cnt == 2'(FIFO_DEPTH));
  assign empty_o = (s_r.cnt == 2'h0);

endmodule
`default_nettype wire

// file: design/uart_rx.sv
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Ninth bit and three error flags are buffered per character; data read advances.
// - Receive-done flag is one exactly while unread characters are buffered.
// - Turning the receiver off flushes the buffer, receive-done goes zero.
// - Interrupt requested while receive-done and its enable are set, gated globally.
// - Writes to the three error flag positions do nothing.
// - Error flags never raise an interrupt.
// - Stop error reflects only the first stop bit; two-stop setting ignored.
// - Overrun when buffer holds two, one more waits, and a start bit arrives.
// - Overrun clears when a character moves from shift register into buffer.
// - Parity checked only when check-on bit set; odd-select picks the kind.
// - Parity computed over data, compared with parity bit, stored with character.
// - Parity error set only for a mismatch checked at reception; valid until read.
// - Parity error reads zero while checking is off.
// - Receiver off acts at once, abandons reception, releases the pin override.
// - Sampling syncs to every start edge and filters each bit by voting.
// - Unused high data bits of short characters read as zero.
// - Start, shift bits, buffer on first stop bit, ignore second stop bit.
// - Start bit voted on samples 8,9,10 or 4,5,6; high majority rejects.
// - Sixteen samples per bit, eight in double speed; three centre samples vote.
module uart_rx
  import uart_rx_pkg::*;
(
  input  wire logic        clk_i,               // 40 MHz system clock
  input  wire logic        nrst_i,              // Async reset, active low
  input  wire logic [4:0]  avs_address_i,       // Byte address
  input  wire logic        avs_read_i,          // Read request
  input  wire logic        avs_write_i,         // Write request
  input  wire logic [31:0] avs_writedata_i,     // Write data
  input  wire logic [3:0]  avs_byteenable_i,    // Byte lanes
  output logic      [31:0] avs_readdata_o,      // Read data
  output logic             avs_waitrequest_o,   // Slave stall
  input  wire logic        rxd_i,               // Serial receive line
  input  wire logic        global_irq_en_i,     // Global interrupt enable
  output logic             rx_irq_o,            // Receive-done interrupt request
  output logic             rx_pin_override_o    // Pin taken over by receiver
);

  typedef struct packed {
    rx_state_t          st;
    logic [4:0]         cnt;
    logic [1:0]         vote;
    logic [3:0]         bit_idx;
    logic [8:0]         shreg;
    logic               par;
    logic               hold_v;
    logic [ENTRY_W-1:0] hold;
    logic               ovr_pend;
    logic               rx_on;
    logic               irq_en;
    logic               par_on;
    logic               par_odd;
    logic               two_stop;
    logic               dspeed;
    logic [2:0]         size;
    logic [7:0]         baud;
    logic               waitreq;
    logic [31:0]        rdata;
    logic               irq;
  } rx_top_state_t;

  rx_top_state_t      s_r;
  rx_top_state_t      s_nxt;
  logic               tick;
  logic [ENTRY_W-1:0] fifo_head;
  logic [1:0]         fifo_count;
  logic               fifo_full;
  logic               fifo_empty;
  logic               push;
  logic [ENTRY_W-1:0] push_din;
  logic               pop;
  logic               flush;
  logic               acc;
  logic [4:0]         spb;
  logic [4:0]         vfirst;
  logic [4:0]         samp;
  logic               vote_now;
  logic               bit_val;
  logic               start_ok;

  baud_tick u_tick (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (s_r.rx_on),
    .div_i  (s_r.baud),
    .tick_o (tick)
  );

  rx_fifo u_fifo (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .push_i  (push),
    .din_i   (push_din),
    .pop_i   (pop),
    .flush_i (flush),
    .head_o  (fifo_head),
    .count_o (fifo_count),
    .full_o  (fifo_full),
    .empty_o (fifo_empty)
  );

  // Request acts on the edge where waitrequest is seen low
  assign acc      = (avs_read_i || avs_write_i) && !s_r.waitreq;
  assign pop      = acc && avs_read_i && (avs_address_i == OFS_DATA);
  assign flush    = !s_r.rx_on;
  assign spb      = s_r.dspeed ? SPB_DOUBLE : SPB_NORMAL;
  assign vfirst   = s_r.dspeed ? VOTE_DOUBLE : VOTE_NORMAL;
  assign samp     = s_r.cnt + 5'h01;
  assign vote_now = tick && (s_r.st != RX_IDLE) && (samp == vfirst + 5'h02);
  assign bit_val  = maj3(s_r.vote[0], s_r.vote[1], rxd_i);
  assign start_ok = vote_now && (s_r.st == RX_START) && !bit_val;

  always_comb begin
    logic [ENTRY_W-1:0] entry;
    logic               perr;
    s_nxt    = s_r;
    push     = 1'b0;
    push_din = s_r.hold;
    perr     = s_r.par_on && (s_r.par ^ s_r.par_odd);
    entry    = {perr, s_r.ovr_pend, ~bit_val, s_r.shreg};

    // A character parked behind a full buffer moves in as soon as room appears
    if (s_r.hold_v && !fifo_full) begin
      push         = 1'b1;
      s_nxt.hold_v = 1'b0;
    end

    if (tick) begin
      unique case (s_r.st)
        RX_IDLE: begin
          if (!rxd_i) begin
            s_nxt.st  = RX_START;
            s_nxt.cnt = 5'h01;
          end
        end
        RX_START, RX_DATA, RX_PARITY, RX_STOP: begin
          s_nxt.cnt = samp;
          if (samp == vfirst) begin
            s_nxt.vote[0] = rxd_i;
          end
          if (samp == vfirst + 5'h01) begin
            s_nxt.vote[1] = rxd_i;
          end
          if (vote_now) begin
            unique case (s_r.st)
              RX_START: begin
                if (bit_val) begin
                  s_nxt.st  = RX_IDLE;
                end else begin
                  s_nxt.shreg   = 9'h000;
                  s_nxt.bit_idx = 4'h0;
                  s_nxt.par     = 1'b0;
                  if (s_r.hold_v && fifo_full) begin
                    s_nxt.ovr_pend = 1'b1;
                    s_nxt.hold_v   = 1'b0;
                  end
                end
              end
              RX_DATA: begin
                s_nxt.shreg[s_r.bit_idx] = bit_val;
                s_nxt.par                = s_r.par ^ bit_val;
              end
              RX_PARITY: begin
                s_nxt.par = s_r.par ^ bit_val;
              end
              RX_STOP: begin
                // First stop bit ends the frame; a second one is never looked at
                s_nxt.st       = RX_IDLE;
                s_nxt.ovr_pend = 1'b0;
                if (!fifo_full && !s_r.hold_v) begin
                  push     = 1'b1;
                  push_din = entry;
                end else begin
                  s_nxt.hold   = entry;
                  s_nxt.hold_v = 1'b1;
                end
              end
            endcase
          end
          if (samp == spb && s_r.st != RX_STOP && s_nxt.st != RX_IDLE) begin
            s_nxt.cnt = 5'h00;
            if (s_r.st == RX_START) begin
              s_nxt.st = RX_DATA;
            end else if (s_r.st == RX_DATA) begin
              if (s_r.bit_idx == last_bit_idx(s_r.size)) begin
                s_nxt.st = s_r.par_on ? RX_PARITY : RX_STOP;
              end else begin
                s_nxt.bit_idx = s_r.bit_idx + 4'h1;
              end
            end else begin
              s_nxt.st = RX_STOP;
            end
          end
        end
        default: begin
          s_nxt.st = RX_IDLE;
        end
      endcase
    end

    // Receiver off wins over everything in flight
    if (!s_r.rx_on) begin
      s_nxt.st       = RX_IDLE;
      s_nxt.cnt      = 5'h00;
      s_nxt.hold_v   = 1'b0;
      s_nxt.ovr_pend = 1'b0;
      push           = 1'b0;
    end

    // Bus: one stall cycle, then the answer
    if ((avs_read_i || avs_write_i) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata   = 32'h0000_0000;
      if (avs_read_i) begin
        unique case (avs_address_i)
          OFS_DATA: begin
            s_nxt.rdata[7:0] = fifo_empty ? 8'h00 : fifo_head[7:0];
          end
          OFS_STATUS: begin
            s_nxt.rdata[ST_DONE]   = !fifo_empty;
            s_nxt.rdata[ST_FERR]   = !fifo_empty && fifo_head[EN_FERR];
            s_nxt.rdata[ST_OVR]    = !fifo_empty && fifo_head[EN_OVR];
            s_nxt.rdata[ST_PERR]   = !fifo_empty && fifo_head[EN_PERR]
                                     && s_r.par_on;
            s_nxt.rdata[ST_DSPEED] = s_r.dspeed;
          end
          OFS_CONTROL: begin
            s_nxt.rdata[CT_IRQ_EN] = s_r.irq_en;
            s_nxt.rdata[CT_RX_ON]  = s_r.rx_on;
            s_nxt.rdata[CT_NINTH]  = !fifo_empty && fifo_head[EN_B8];
          end
          OFS_FORMAT: begin
            s_nxt.rdata[FM_PAR_ON]   = s_r.par_on;
            s_nxt.rdata[FM_PAR_ODD]  = s_r.par_odd;
            s_nxt.rdata[FM_TWO_STOP] = s_r.two_stop;
            s_nxt.rdata[2:0]         = s_r.size;
          end
          OFS_BAUD: begin
            s_nxt.rdata[7:0] = s_r.baud;
          end
          default: begin
          end
        endcase
      end
    end else begin
      s_nxt.waitreq = 1'b1;
    end

    if (acc && avs_write_i && avs_byteenable_i[0]) begin
      unique case (avs_address_i)
        OFS_STATUS: begin
          s_nxt.dspeed = avs_writedata_i[ST_DSPEED];
        end
        OFS_CONTROL: begin
          s_nxt.irq_en = avs_writedata_i[CT_IRQ_EN];
          s_nxt.rx_on  = avs_writedata_i[CT_RX_ON];
        end
        OFS_FORMAT: begin
          s_nxt.par_on   = avs_writedata_i[FM_PAR_ON];
          s_nxt.par_odd  = avs_writedata_i[FM_PAR_ODD];
          s_nxt.two_stop = avs_writedata_i[FM_TWO_STOP];
          s_nxt.size     = avs_writedata_i[2:0];
        end
        OFS_BAUD: begin
          s_nxt.baud = avs_writedata_i[7:0];
        end
        default: begin
        end
      endcase
    end

    // Error flags deliberately left out of the request
    s_nxt.irq = s_r.irq_en && !fifo_empty && global_irq_en_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r         <= '0;
      s_r.st      <= RX_IDLE;
      s_r.size    <= SIZE_RST;
      s_r.baud    <= BAUD_RST;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o    = s_r.rdata;
  assign avs_waitrequest_o = s_r.waitreq;
  assign rx_irq_o          = s_r.irq;
  assign rx_pin_override_o = s_r.rx_on;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  irq_follows_flag_a: assert property (s_r.irq_en && !fifo_empty && global_irq_en_i |=> rx_irq_o)
    else $error("interrupt not requested with data pending");
  irq_no_data_a: assert property (fifo_empty |=> !rx_irq_o)
    else $error("interrupt requested with empty buffer");
  flush_on_off_a: assert property (!s_r.rx_on |=> fifo_empty && s_r.st == RX_IDLE)
    else $error("receiver off did not flush and abort");
  override_release_a: assert property ($fell(rx_pin_override_o) |=> s_r.st == RX_IDLE
      && !s_r.hold_v && fifo_empty)
    else $error("receiver off left reception running");
  done_status_a: assert property (avs_read_i && s_r.waitreq && avs_address_i == OFS_STATUS
      |=> avs_readdata_o[ST_DONE] == !$past(fifo_empty))
    else $error("status done bit wrong");
  parity_off_zero_a: assert property (avs_read_i && s_r.waitreq && !s_r.par_on
      && avs_address_i == OFS_STATUS |=> !avs_readdata_o[ST_PERR])
    else $error("parity error seen with checking off");
  data_pop_a: assert property (pop && !fifo_empty && !push && s_r.rx_on
      |=> fifo_count == $past(fifo_count) - 2'h1)
    else $error("data read did not advance buffer");
  flags_write_a: assert property (acc && avs_write_i && avs_address_i == OFS_STATUS
      && !fifo_empty && s_r.rx_on |=> $stable(fifo_head))
    else $error("status write altered buffered flags");
  start_reject_a: assert property (vote_now && s_r.st == RX_START && bit_val && s_r.rx_on
      |=> s_r.st == RX_IDLE)
    else $error("noise start bit not rejected");
  overrun_set_a: assert property (start_ok && s_r.hold_v && fifo_full && s_r.rx_on
      |=> s_r.ovr_pend ##0 !s_r.hold_v)
    else $error("overrun not flagged");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");
  frame_pushed_c: cover property (push && push_din[EN_PERR]);
  overrun_c: cover property (start_ok && s_r.hold_v && fifo_full);
  noise_start_c: cover property (vote_now && s_r.st == RX_START && bit_val);
  irq_raised_c: cover property ($rose(rx_irq_o));

endmodule
`default_nettype wire

// file: bench/serial_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
  input  wire logic       clk_i,  // System clock
  input  wire logic [4:0] spb_i,  // Clocks per bit
  output var  logic       rxd_o   // Serial line into receiver
);
  initial rxd_o = 1'h1;

  task automatic put(input logic b);
    rxd_o <= b;
    repeat (spb_i) @(posedge clk_i);
  endtask

  // Start, data LSB first, optional parity, one stop, then idle high
  task automatic send(input logic [8:0] d, input int nb, input logic par_on,
                      input logic odd, input logic par_bad, input logic stop_bad);
    logic p;
    p = ^(d & 9'((1 << nb) - 1)) ^ odd ^ par_bad;
    @(posedge clk_i);
    put(1'h0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (par_on) put(p);
    put(~stop_bad);
    rxd_o <= 1'h1;
  endtask

  // Short low pulse, too brief to survive the start vote
  task automatic glitch();
    @(posedge clk_i);
    rxd_o <= 1'h0;
    repeat (3) @(posedge clk_i);
    rxd_o <= 1'h1;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import uart_rx_pkg::*;
;
  logic        clk_i;
  logic        nrst_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic        global_irq_en_i;
  logic [4:0]  avs_address_i;
  logic [4:0]  spb;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic [31:0] rd;
  logic        avs_waitrequest_o;
  logic        rx_irq_o;
  logic        rx_pin_override_o;
  logic        rxd;
  logic        ov;
  int          fail_count;
  int          check_count;

  uart_rx DUT (
    .clk_i             (clk_i),
    .nrst_i            (nrst_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (4'hF),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .rxd_i             (rxd),
    .global_irq_en_i   (global_irq_en_i),
    .rx_irq_o          (rx_irq_o),
    .rx_pin_override_o (rx_pin_override_o)
  );

  serial_tx_model tx (
    .clk_i (clk_i),
    .spb_i (spb),
    .rxd_o (rxd)
  );

  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 100);
    rd = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
    if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'h0, a, 8'h00);
    chk(nm, e, rd);
  endtask

  initial begin
    #2000000;
    fail_count++;
    close_out();
  end

  initial begin
    nrst_i = 1'h0;
    avs_read_i = 1'h0;
    avs_write_i = 1'h0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    global_irq_en_i = 1'h1;
    spb = 5'h10;
    fail_count = 0;
    check_count = 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'h1;
    rdchk(OFS_CONTROL, 32'h0, "control");
    rdchk(OFS_FORMAT, 32'h3, "format");
    rdchk(OFS_BAUD, 32'h0, "baud");
    rdchk(5'h14, 32'h0, "unmapped");
    chk("override", 32'h0, {31'h0, rx_pin_override_o});
    bus(1'h1, OFS_CONTROL, 8'h90);
    rdchk(OFS_CONTROL, 32'h90, "control");
    chk("override", 32'h1, {31'h0, rx_pin_override_o});
    tx.send(9'h0A5, 8, 1'h0, 1'h0, 1'h0, 1'h0);
    rdchk(OFS_STATUS, 32'h80, "status");
    chk("irq", 32'h1, {31'h0, rx_irq_o});
    global_irq_en_i <= 1'h0;
    rdchk(OFS_STATUS, 32'h80, "status");
    chk("irq", 32'h0, {31'h0, rx_irq_o});
    global_irq_en_i <= 1'h1;
    rdchk(OFS_DATA, 32'hA5, "data");
    rdchk(OFS_STATUS, 32'h0, "status");
    chk("irq", 32'h0, {31'h0, rx_irq_o});
    // Every parity kind, with and without a corrupted parity bit
    for (int m = 0; m < 4; m++) begin
      bus(1'h1, OFS_FORMAT, {2'h0, 1'h1, m[0], 1'h0, 3'h3});
      tx.send(9'h03C, 8, 1'h1, m[0], m[1], 1'h0);
      bus(1'h1, OFS_STATUS, 8'h1C);
      rdchk(OFS_STATUS, m[1] ? 32'h84 : 32'h80, "status");
      rdchk(OFS_DATA, 32'h3C, "data");
    end
    bus(1'h1, OFS_FORMAT, 8'h0B);
    tx.send(9'h081, 8, 1'h0, 1'h0, 1'h0, 1'h1);
    rdchk(OFS_STATUS, 32'h90, "status");
    rdchk(OFS_DATA, 32'h81, "data");
    // Four frames unread: the held third is lost when the fourth starts
    bus(1'h1, OFS_FORMAT, 8'h03);
    ov = 1'h0;
    for (int i = 1; i <= 4; i++) tx.send(9'(32'h11 * i), 8, 1'h0, 1'h0, 1'h0, 1'h0);
    for (int i = 1; i <= 3; i++) begin
      bus(1'h0, OFS_STATUS, 8'h00);
      ov = ov | rd[ST_OVR];
      chk("overrun", {31'h0, i == 3}, {31'h0, rd[ST_OVR]});
      rdchk(OFS_DATA, (i == 3) ? 32'h44 : 32'h11 * i, "data");
    end
    chk("overrun", 32'h1, {31'h0, ov});
    rdchk(OFS_STATUS, 32'h0, "status");
    tx.send(9'h066, 8, 1'h0, 1'h0, 1'h0, 1'h0);
    rdchk(OFS_STATUS, 32'h80, "status");
    rdchk(OFS_DATA, 32'h66, "data");
    bus(1'h1, OFS_FORMAT, 8'h07);
    tx.send(9'h155, 9, 1'h0, 1'h0, 1'h0, 1'h0);
    rdchk(OFS_CONTROL, 32'h92, "ninth");
    rdchk(OFS_DATA, 32'h55, "data");
    bus(1'h1, OFS_FORMAT, 8'h00);
    tx.send(9'h0FF, 5, 1'h0, 1'h0, 1'h0, 1'h0);
    rdchk(OFS_DATA, 32'h1F, "data");
    bus(1'h1, OFS_FORMAT, 8'h03);
    bus(1'h1, OFS_STATUS, 8'h02);
    spb = 5'h08;
    tx.send(9'h05A, 8, 1'h0, 1'h0, 1'h0, 1'h0);
    rdchk(OFS_STATUS, 32'h82, "status");
    rdchk(OFS_DATA, 32'h5A, "data");
    // Divider at two clocks per sample: eight samples span sixteen clocks
    bus(1'h1, OFS_BAUD, 8'h01);
    rdchk(OFS_BAUD, 32'h1, "baud");
    spb = 5'h10;
    tx.send(9'h0C3, 8, 1'h0, 1'h0, 1'h0, 1'h0);
    rdchk(OFS_STATUS, 32'h82, "status");
    rdchk(OFS_DATA, 32'hC3, "data");
    bus(1'h1, OFS_BAUD, 8'h00);
    bus(1'h1, OFS_STATUS, 8'h00);
    spb = 5'h10;
    tx.glitch();
    repeat (40) @(posedge clk_i);
    rdchk(OFS_STATUS, 32'h0, "status");
    tx.send(9'h077, 8, 1'h0, 1'h0, 1'h0, 1'h0);
    bus(1'h1, OFS_CONTROL, 8'h80);
    rdchk(OFS_STATUS, 32'h0, "status");
    chk("override", 32'h0, {31'h0, rx_pin_override_o});
    chk("irq", 32'h0, {31'h0, rx_irq_o});
    close_out();
  end
endmodule
`default_nettype wire
